// *** rtl/dmbc_ctrl_end.sv ***
`timescale 1ns/1ns
// Function
// - command codes from select and strobe pins
// - nop and deselect let operations continue
// - idle other bank: bank m's own state decides
// - busy other bank still allows bank m commands
// - rules valid only with clock gate high
// - idle means precharged and precharge time met
// - row active after activate-to-column delay elapsed
// - read autoprecharge: precharge at earliest legal point
// - write autoprecharge: precharge after write recovery
// - other banks usable, avoid data bus collisions
// - write autoprecharge to read: latency+burst+recovery
// - half burst between same-direction accesses
// - read autoprecharge to write: turnaround delay
// - one clock before precharge or activate
// - refresh and mode load need all idle
// - never issue unlisted command combinations
// - mask leftover write data when reading
module dmbc_ctrl_end
    import dmbc_pkg::*;
#(
    parameter int NB = NUM_BANKS
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst_n,
    dmbc_if.ctrl                   bus,
    input  wire logic              i_cmd_valid,
    input  wire dmbc_cmd_t         i_cmd,
    input  wire logic [BA_W-1:0]   i_bank,
    input  wire logic              i_ap,
    input  wire logic [DQ_W-1:0]   i_wr_data,
    input  wire logic [MASK_W-1:0] i_wr_mask,
    output logic                   o_cmd_done,
    output logic                   o_rd_valid,
    output logic      [DQ_W-1:0]   o_rd_data,
    output logic      [NB-1:0]     o_bank_idle
);
    dmbc_bank_t       st_reg  [NB];
    logic [CNT_W-1:0] cnt_reg [NB];
    logic [NB-1:0]    idle;
    logic [NB-1:0]    sel;
    logic [NB-1:0]    hit;
    logic             cke_prev_reg;
    logic [CNT_W-1:0] since_wap_reg;
    logic [CNT_W-1:0] since_rap_reg;
    logic [CNT_W-1:0] since_wr_reg;
    logic [CNT_W-1:0] since_rd_reg;
    logic [WR_PIPE-1:0] wr_sh_reg;
    logic             mask_rest_reg;
    logic             bank_cmd;
    logic             state_ok;
    logic             time_ok;
    logic             issue;
    logic             is_rd;
    logic             is_wr;

    assign bank_cmd = (i_cmd == CMD_ACT) || (i_cmd == CMD_RD)
                      || (i_cmd == CMD_WR) || (i_cmd == CMD_PRE);
    assign is_rd    = issue && i_cmd == CMD_RD;
    assign is_wr    = issue && i_cmd == CMD_WR;

    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_bank
            assign idle[g] = (st_reg[g] == BK_IDLE) && (cnt_reg[g] == '0);
            assign sel[g]  = (i_bank == BA_W'(g))
                             && dmbc_legal(st_reg[g], i_cmd);
            assign hit[g]  = issue && bank_cmd && (i_bank == BA_W'(g));
            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    st_reg[g]  <= BK_IDLE;
                    cnt_reg[g] <= '0;
                end else
                    {st_reg[g], cnt_reg[g]} <= dmbc_bk_step(st_reg[g],
                        cnt_reg[g], hit[g], i_cmd, i_ap);
            end
        end
    endgenerate

    always_comb begin
        state_ok = 1'b0;
        case (i_cmd)
            CMD_ACT, CMD_RD, CMD_WR,
            CMD_PRE:          state_ok = |sel;
            CMD_REF, CMD_LMR: state_ok = &idle;
            CMD_DTD:          state_ok = 1'b1;
            default:          state_ok = 1'b0;
        endcase
    end

    // reads and writes use the same bounds after plain accesses to keep the bus clean, except a read after a plain write waits only BL2
    always_comb begin
        time_ok = 1'b1;
        case (i_cmd)
            CMD_RD: time_ok = (since_wap_reg >= CNT_W'(WAP_TO_RD))
                && (since_rap_reg >= CNT_W'(BL2))
                && (since_rd_reg >= CNT_W'(BL2))
                && (since_wr_reg >= CNT_W'(BL2));
            CMD_WR: time_ok = (since_wap_reg >= CNT_W'(BL2))
                && (since_rap_reg >= CNT_W'(RAP_TO_WR))
                && (since_rd_reg >= CNT_W'(RAP_TO_WR))
                && (since_wr_reg >= CNT_W'(BL2));
            CMD_ACT, CMD_PRE:
                time_ok = (since_wap_reg >= CNT_W'(AP_TO_ACTPRE))
                    && (since_rap_reg >= CNT_W'(AP_TO_ACTPRE));
            default: time_ok = 1'b1;
        endcase
    end

    // done pulse blocks a second issue of the same held request
    assign issue = i_cmd_valid && !o_cmd_done && cke_prev_reg
                   && state_ok && time_ok;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.cke      <= 1'b0;
            cke_prev_reg <= 1'b0;
        end else begin
            bus.cke      <= 1'b1;
            cke_prev_reg <= bus.cke;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.cs_n   <= 1'b1;
            bus.ras_n  <= 1'b1;
            bus.cas_n  <= 1'b1;
            bus.we_n   <= 1'b1;
            bus.ba     <= '0;
            bus.ap     <= 1'b0;
            o_cmd_done <= 1'b0;
        end else begin
            o_cmd_done <= issue;
            bus.ba     <= i_bank;
            bus.ap     <= i_ap;
            bus.cs_n   <= 1'b1;
            bus.ras_n  <= 1'b1;
            bus.cas_n  <= 1'b1;
            bus.we_n   <= 1'b1;
            if (issue) begin
                bus.cs_n <= 1'b0;
                case (i_cmd)
                    CMD_ACT: {bus.ras_n, bus.cas_n, bus.we_n} <= 3'h3;
                    CMD_RD:  {bus.ras_n, bus.cas_n, bus.we_n} <= 3'h5;
                    CMD_WR:  {bus.ras_n, bus.cas_n, bus.we_n} <= 3'h4;
                    CMD_PRE: {bus.ras_n, bus.cas_n, bus.we_n} <= 3'h2;
                    CMD_REF: {bus.ras_n, bus.cas_n, bus.we_n} <= 3'h1;
                    CMD_LMR: {bus.ras_n, bus.cas_n, bus.we_n} <= 3'h0;
                    CMD_DTD: begin
                        bus.cs_n <= 1'b1;
                        {bus.ras_n, bus.cas_n, bus.we_n} <= 3'h5;
                    end
                    default: bus.cs_n <= 1'b1;
                endcase
            end
        end
    end

    // saturating ages of the last access of each kind
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            since_wap_reg <= '1;
            since_rap_reg <= '1;
            since_wr_reg  <= '1;
            since_rd_reg  <= '1;
        end else begin
            since_wap_reg <= (is_wr && i_ap) ? '0 : since_wap_reg
                + CNT_W'(since_wap_reg != '1);
            since_rap_reg <= (is_rd && i_ap) ? '0 : since_rap_reg
                + CNT_W'(since_rap_reg != '1);
            since_wr_reg  <= (is_wr && !i_ap) ? '0 : since_wr_reg
                + CNT_W'(since_wr_reg != '1);
            since_rd_reg  <= (is_rd && !i_ap) ? '0 : since_rd_reg
                + CNT_W'(since_rd_reg != '1);
        end
    end

    // write beats follow write_latency; a read cuts the tail by masking
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_sh_reg          <= '0;
            mask_rest_reg      <= 1'b0;
            bus.wvalid         <= 1'b0;
            bus.wdq            <= '0;
            bus.byte_mask_lane <= '0;
        end else begin
            wr_sh_reg  <= {wr_sh_reg[WR_PIPE-2:0], is_wr};
            if (is_rd && |wr_sh_reg)
                mask_rest_reg <= 1'b1;
            else if (!(|wr_sh_reg))
                mask_rest_reg <= 1'b0;
            bus.wvalid <= |wr_sh_reg[WRITE_LATENCY-2 +: BL2];
            bus.wdq    <= i_wr_data;
            bus.byte_mask_lane <= (mask_rest_reg || (is_rd && |wr_sh_reg))
                ? '1 : i_wr_mask;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_valid  <= 1'b0;
            o_rd_data   <= '0;
            o_bank_idle <= '1;
        end else begin
            o_rd_valid  <= bus.rvalid;
            o_rd_data   <= bus.rdq;
            o_bank_idle <= idle;
        end
    end
endmodule

// *** rtl/dmbc_pkg.sv ***
package dmbc_pkg;
    localparam int NUM_BANKS = 4;
    localparam int BA_W      = 2;
    localparam int DQ_W      = 32;
    localparam int MASK_W    = 4;
    localparam int CNT_W     = 8;

    // clock and analog-free timing, times in ns
    localparam int CLK_NS    = 20;
    localparam int T_RP_NS   = 40;
    localparam int T_RCD_NS  = 40;
    localparam int T_WR_NS   = 30;
    localparam int T_XSNR_NS = 200;
    localparam int RP_CYC    = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RCD_CYC   = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_CYC    = (T_WR_NS + CLK_NS - 1) / CLK_NS;
    localparam int XSNR_CYC  = (T_XSNR_NS + CLK_NS - 1) / CLK_NS;

    // latencies and burst in clocks
    localparam int WRITE_LATENCY = 3;
    localparam int READ_LATENCY  = 7;
    localparam int BURST_LENGTH  = 4;
    localparam int BL2           = BURST_LENGTH / 2;
    localparam int WAP_TO_RD     = WRITE_LATENCY + BL2 + WR_CYC;
    localparam int RAP_TO_WR     = READ_LATENCY + BL2 + 1 - WRITE_LATENCY + 1;
    localparam int AP_TO_ACTPRE  = 1;
    localparam int RD_PIPE       = READ_LATENCY + BL2;
    localparam int WR_PIPE       = WRITE_LATENCY + BL2;

    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_ACT = 3'h1,
        CMD_RD  = 3'h2,
        CMD_WR  = 3'h3,
        CMD_PRE = 3'h4,
        CMD_REF = 3'h5,
        CMD_LMR = 3'h6,
        CMD_DTD = 3'h7
    } dmbc_cmd_t;

    typedef enum logic [2:0] {
        BK_IDLE = 3'h0,
        BK_ACTG = 3'h1,
        BK_ACT  = 3'h2,
        BK_RD   = 3'h3,
        BK_WR   = 3'h4,
        BK_RDAP = 3'h5,
        BK_WRAP = 3'h6,
        BK_PRE  = 3'h7
    } dmbc_bank_t;

    function automatic dmbc_cmd_t dmbc_decode(input logic cs_n,
        input logic ras_n, input logic cas_n, input logic we_n);
        dmbc_cmd_t c;
        c = CMD_NOP;
        if (ras_n && !cas_n && we_n && cs_n)
            c = CMD_DTD;
        else if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'h3:    c = CMD_ACT;
                3'h5:    c = CMD_RD;
                3'h4:    c = CMD_WR;
                3'h2:    c = CMD_PRE;
                3'h1:    c = CMD_REF;
                3'h0:    c = CMD_LMR;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    // bank m's own state decides; other banks never block
    function automatic logic dmbc_legal(input dmbc_bank_t st,
        input dmbc_cmd_t c);
        logic ok;
        ok = 1'b0;
        case (c)
            CMD_ACT:         ok = (st == BK_IDLE);
            CMD_RD, CMD_WR,
            CMD_PRE:         ok = (st == BK_ACT) || (st == BK_RD)
                                  || (st == BK_WR);
            default:         ok = 1'b0;
        endcase
        return ok;
    endfunction

    // returns {state, count}; count holds cycles left minus one
    function automatic logic [CNT_W+2:0] dmbc_bk_step(input dmbc_bank_t st,
        input logic [CNT_W-1:0] cnt, input logic hit, input dmbc_cmd_t c,
        input logic ap);
        dmbc_bank_t ns;
        logic [CNT_W-1:0] nc;
        ns = st;
        nc = cnt;
        if (hit) begin
            case (c)
                CMD_ACT: begin
                    ns = BK_ACTG;
                    nc = CNT_W'(RCD_CYC - 1);
                end
                CMD_RD: begin
                    ns = ap ? BK_RDAP : BK_RD;
                    nc = ap ? CNT_W'(BL2 - 1) : CNT_W'(RD_PIPE - 1);
                end
                CMD_WR: begin
                    ns = ap ? BK_WRAP : BK_WR;
                    nc = ap ? CNT_W'(WR_PIPE + WR_CYC - 1)
                            : CNT_W'(WR_PIPE - 1);
                end
                default: begin
                    ns = BK_PRE;
                    nc = CNT_W'(RP_CYC - 1);
                end
            endcase
        end else if (cnt != '0)
            nc = cnt - 1'b1;
        else begin
            case (st)
                BK_ACTG, BK_RD, BK_WR: ns = BK_ACT;
                BK_RDAP, BK_WRAP: begin
                    ns = BK_PRE;
                    nc = CNT_W'(RP_CYC - 1);
                end
                BK_PRE:  ns = BK_IDLE;
                default: ns = st;
            endcase
        end
        return {ns, nc};
    endfunction
endpackage

// *** rtl/dmbc_if.sv ***
`timescale 1ns/1ns
interface dmbc_if;
    import dmbc_pkg::*;
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic              ap;
    logic [DQ_W-1:0]   wdq;
    logic [MASK_W-1:0] byte_mask_lane;
    logic              wvalid;
    logic [DQ_W-1:0]   rdq;
    logic              rvalid;

    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, ap, wdq,
                  byte_mask_lane, wvalid, input rdq, rvalid);
    modport dram (input cke, cs_n, ras_n, cas_n, we_n, ba, ap, wdq,
                  byte_mask_lane, wvalid, output rdq, rvalid);
endinterface

// *** rtl/dmbc_dram_end.sv ***
`timescale 1ns/1ns
module dmbc_dram_end
    import dmbc_pkg::*;
#(
    parameter int NB = NUM_BANKS
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst_n,
    dmbc_if.dram                   bus,
    input  wire logic [DQ_W-1:0]   i_rd_data,
    output logic      [DQ_W-1:0]   o_wr_data,
    output logic      [MASK_W-1:0] o_wr_mask,
    output logic                   o_wr_valid,
    output logic                   o_cmd_error,
    output logic                   o_term_off,
    output logic      [NB-1:0]     o_bank_idle
);
    dmbc_cmd_t        cmd;
    dmbc_bank_t       st_reg  [NB];
    logic [CNT_W-1:0] cnt_reg [NB];
    logic [NB-1:0]    hit;
    logic [NB-1:0]    idle;
    logic [NB-1:0]    legal;
    logic             cke_prev_reg;
    logic             sr_reg;
    logic [CNT_W-1:0] xs_cnt_reg;
    logic             live;
    logic             bank_cmd;
    logic             all_idle;
    logic [RD_PIPE-1:0] rd_sh_reg;

    assign cmd      = dmbc_decode(bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n);
    assign live     = cke_prev_reg && bus.cke && !sr_reg
                      && (xs_cnt_reg == '0);
    assign bank_cmd = (cmd == CMD_ACT) || (cmd == CMD_RD)
                      || (cmd == CMD_WR) || (cmd == CMD_PRE);
    assign all_idle = &idle;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n)
            cke_prev_reg <= 1'b0;
        else
            cke_prev_reg <= bus.cke;
    end

    // self refresh: entered by refresh with clock gate falling
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sr_reg     <= 1'b0;
            xs_cnt_reg <= '0;
        end else if (sr_reg) begin
            if (bus.cke) begin
                sr_reg     <= 1'b0;
                xs_cnt_reg <= CNT_W'(XSNR_CYC);
            end
        end else if (cke_prev_reg && !bus.cke && cmd == CMD_REF
                     && all_idle)
            sr_reg <= 1'b1;
        else if (xs_cnt_reg != '0)
            xs_cnt_reg <= xs_cnt_reg - 1'b1;
    end

    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_bank
            assign idle[g]  = (st_reg[g] == BK_IDLE) && (cnt_reg[g] == '0);
            assign legal[g] = dmbc_legal(st_reg[g], cmd);
            assign hit[g]   = live && bank_cmd && (bus.ba == BA_W'(g))
                              && legal[g];
            // nop and deselect just let the counters run
            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    st_reg[g]  <= BK_IDLE;
                    cnt_reg[g] <= '0;
                end else
                    {st_reg[g], cnt_reg[g]} <= dmbc_bk_step(st_reg[g],
                        cnt_reg[g], hit[g], cmd, bus.ap);
            end
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cmd_error <= 1'b0;
            o_term_off  <= 1'b0;
            o_bank_idle <= '1;
        end else begin
            o_cmd_error <= live && ((bank_cmd && !(|hit))
                || ((cmd == CMD_REF || cmd == CMD_LMR) && !all_idle));
            o_term_off  <= bus.cke && (cmd == CMD_DTD);
            o_bank_idle <= idle;
        end
    end

    // read data leaves read_latency after the command, one word a clock
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_sh_reg  <= '0;
            bus.rvalid <= 1'b0;
            bus.rdq    <= '0;
        end else begin
            rd_sh_reg  <= {rd_sh_reg[RD_PIPE-2:0], |(hit) && cmd == CMD_RD};
            bus.rvalid <= |rd_sh_reg[READ_LATENCY-2 +: BL2];
            bus.rdq    <= i_rd_data;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wr_valid <= 1'b0;
            o_wr_data  <= '0;
            o_wr_mask  <= '0;
        end else begin
            o_wr_valid <= bus.wvalid && !(&bus.byte_mask_lane);
            o_wr_data  <= bus.wdq;
            o_wr_mask  <= bus.byte_mask_lane;
        end
    end
endmodule

// *** dv/dmbc_props.sv ***
`timescale 1ns/1ns
module dmbc_props
    import dmbc_pkg::*;
(
    input wire logic            i_mclk,
    input wire logic            i_rst_n,
    input wire logic            cke,
    input wire logic            cs_n,
    input wire logic            ras_n,
    input wire logic            cas_n,
    input wire logic            we_n,
    input wire logic [BA_W-1:0] ba,
    input wire logic            ap,
    input wire logic            wvalid,
    input wire logic            rvalid
);
    localparam int WV_DLY = WRITE_LATENCY - 1;
    localparam int RV_MIN = READ_LATENCY - 2;
    localparam int RV_MAX = READ_LATENCY;
    logic                 c_act;
    logic                 c_rd;
    logic                 c_wr;
    logic                 c_pre;
    logic [7:0]           age_wap;
    logic [7:0]           age_rap;
    logic [BA_W-1:0]      bk_wap;
    logic [BA_W-1:0]      bk_rap;
    logic [NUM_BANKS-1:0] row_open;

    assign c_act = !cs_n && !ras_n && cas_n && we_n;
    assign c_rd  = !cs_n && ras_n && !cas_n && we_n;
    assign c_wr  = !cs_n && ras_n && !cas_n && !we_n;
    assign c_pre = !cs_n && !ras_n && cas_n && !we_n;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    // saturating ages stand in for local variables, which some tools lack
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            age_wap <= 8'hFF;
            bk_wap  <= '0;
        end else if (c_wr && ap) begin
            age_wap <= 8'h01;
            bk_wap  <= ba;
        end else if (age_wap != 8'hFF) begin
            age_wap <= age_wap + 8'h01;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            age_rap <= 8'hFF;
            bk_rap  <= '0;
        end else if (c_rd && ap) begin
            age_rap <= 8'h01;
            bk_rap  <= ba;
        end else if (age_rap != 8'hFF) begin
            age_rap <= age_rap + 8'h01;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            row_open <= '0;
        end else if (c_act) begin
            row_open[ba] <= 1'b1;
        end else if (c_pre || ((c_rd || c_wr) && ap)) begin
            row_open[ba] <= 1'b0;
        end
    end

    property p_cke_on;
        $past(i_rst_n) |-> cke;
    endproperty
    a_cke_on: assert property (p_cke_on)
        else $error("clock gate low after reset");

    property p_cmd_cke;
        !cs_n |-> cke && $past(cke);
    endproperty
    a_cmd_cke: assert property (p_cmd_cke)
        else $error("command without clock gate");

    property p_one_cyc;
        !cs_n |=> cs_n || (ras_n && cas_n && we_n);
    endproperty
    a_one_cyc: assert property (p_one_cyc)
        else $error("command held two cycles");

    property p_wap_rd;
        c_rd && ba != bk_wap |-> age_wap >= 8'(WAP_TO_RD);
    endproperty
    a_wap_rd: assert property (p_wap_rd)
        else $error("read too soon after write ap");

    property p_wap_wr;
        c_wr && ba != bk_wap |-> age_wap >= 8'(BL2);
    endproperty
    a_wap_wr: assert property (p_wap_wr)
        else $error("write too soon after write ap");

    property p_rap_rd;
        c_rd && ba != bk_rap |-> age_rap >= 8'(BL2);
    endproperty
    a_rap_rd: assert property (p_rap_rd)
        else $error("read too soon after read ap");

    property p_rap_wr;
        c_wr && ba != bk_rap |-> age_rap >= 8'(RAP_TO_WR);
    endproperty
    a_rap_wr: assert property (p_rap_wr)
        else $error("write too soon after read ap");

    property p_act_closed;
        c_act |-> !row_open[ba];
    endproperty
    a_act_closed: assert property (p_act_closed)
        else $error("activate to open bank");

    property p_acc_open;
        c_rd || c_wr || c_pre |-> row_open[ba];
    endproperty
    a_acc_open: assert property (p_acc_open)
        else $error("access to closed bank");

    property p_wr_beats;
        c_wr |-> ##WV_DLY wvalid ##1 wvalid;
    endproperty
    a_wr_beats: assert property (p_wr_beats)
        else $error("write beats misplaced");

    property p_rd_beats;
        c_rd |-> ##[RV_MIN:RV_MAX] rvalid;
    endproperty
    a_rd_beats: assert property (p_rd_beats)
        else $error("read data missing");
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    import dmbc_pkg::*;
    typedef struct {
        dmbc_cmd_t  cmd;
        logic [1:0] bk;
        logic       ap;
        int         ref_row;
        int         gap;
    } dmbc_row_t;

    logic                 i_mclk;
    logic                 i_rst_n;
    logic                 cmd_valid;
    dmbc_cmd_t            cmd;
    logic [BA_W-1:0]      bank;
    logic                 cmd_ap;
    logic [DQ_W-1:0]      wr_data;
    logic [MASK_W-1:0]    wr_mask;
    logic [DQ_W-1:0]      rd_data;
    logic                 cmd_done;
    logic                 rd_valid;
    logic                 wr_valid;
    logic                 cmd_error;
    logic                 term_off;
    logic [DQ_W-1:0]      rd_out;
    logic [DQ_W-1:0]      wr_out;
    logic [MASK_W-1:0]    mask_out;
    logic [NUM_BANKS-1:0] ctl_idle;
    logic [NUM_BANKS-1:0] dev_idle;
    int                   err_total;
    int                   tests_run;
    int                   wr_beats;
    int                   rd_beats;
    int                   terms;
    int                   t_done [12];
    dmbc_row_t            rows [12];

    dmbc_if bus_if ();

    dmbc_ctrl_end dmbc_ctrl_end_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .bus(bus_if), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_bank(bank),
        .i_ap(cmd_ap), .i_wr_data(wr_data), .i_wr_mask(wr_mask),
        .o_cmd_done(cmd_done), .o_rd_valid(rd_valid), .o_rd_data(rd_out),
        .o_bank_idle(ctl_idle));

    dmbc_dram_end dmbc_dram_end_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .bus(bus_if), .i_rd_data(rd_data), .o_wr_data(wr_out),
        .o_wr_mask(mask_out), .o_wr_valid(wr_valid),
        .o_cmd_error(cmd_error), .o_term_off(term_off),
        .o_bank_idle(dev_idle));

    dmbc_props dmbc_props_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .cke(bus_if.cke), .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n),
        .cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .ba(bus_if.ba),
        .ap(bus_if.ap), .wvalid(bus_if.wvalid), .rvalid(bus_if.rvalid));

    initial i_mclk = 1'b0;
    always #10 i_mclk = ~i_mclk;

    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // request held until done; lim cycles without done means refused
    task automatic issue(input dmbc_cmd_t c, input logic [1:0] b,
                         input logic a, input int lim, output int n);
        @(posedge i_mclk);
        #1;
        cmd_valid = 1'b1;
        cmd = c;
        bank = b;
        cmd_ap = a;
        n = 0;
        while (cmd_done !== 1'b1 && n < lim) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        cmd_valid = 1'b0;
    endtask

    task automatic idle_wait(input logic [3:0] m, output int k);
        k = 0;
        while ((dev_idle & m) !== m && k < 60) begin
            @(posedge i_mclk);
            #1;
            k++;
        end
    endtask

    always @(posedge i_mclk) begin
        #1;
        if (wr_valid === 1'b1) begin
            wr_beats++;
            check(wr_out === wr_data && mask_out === wr_mask, "wdata");
        end
        if (rd_valid === 1'b1) begin
            rd_beats++;
            check(rd_out === rd_data, "read data");
        end
        if (term_off === 1'b1) begin
            terms++;
        end
        if (i_rst_n === 1'b1 && cmd_error !== 1'b0) begin
            check(1'b0, "device flagged a command");
        end
    end

    initial begin
        #(20 * 5000);
        err_total++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        test_done();
    end

    initial begin
        int n;
        int g;
        int k0;
        int k1;
        int k2;
        int b0;
        i_rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = CMD_NOP;
        bank = 2'h0;
        cmd_ap = 1'b0;
        wr_data = 32'hA5C30F96;
        wr_mask = 4'h0;
        rd_data = 32'h5A3CF069;
        err_total = 0;
        tests_run = 0;
        wr_beats = 0;
        rd_beats = 0;
        terms = 0;
        rows = '{'{CMD_ACT, 2'h0, 1'b0, 0, 0}, '{CMD_ACT, 2'h1, 1'b0, 1, 0},
            '{CMD_ACT, 2'h2, 1'b0, 2, 0}, '{CMD_WR, 2'h0, 1'b0, 3, 0},
            '{CMD_WR, 2'h1, 1'b1, 3, BL2}, '{CMD_RD, 2'h0, 1'b1, 4, WAP_TO_RD},
            '{CMD_WR, 2'h2, 1'b1, 5, RAP_TO_WR},
            '{CMD_ACT, 2'h3, 1'b0, 6, AP_TO_ACTPRE},
            '{CMD_RD, 2'h3, 1'b1, 6, WAP_TO_RD}, '{CMD_ACT, 2'h0, 1'b0, 8, 1},
            '{CMD_RD, 2'h0, 1'b0, 8, BL2}, '{CMD_PRE, 2'h0, 1'b0, 11, 0}};
        repeat (5) @(posedge i_mclk);
        #1;
        check(ctl_idle === 4'hF && dev_idle === 4'hF, "reset idle");
        check(cmd_done === 1'b0 && wr_valid === 1'b0, "reset outputs");
        i_rst_n = 1'b1;
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            issue(rows[i].cmd, rows[i].bk, rows[i].ap, 60, n);
            t_done[i] = int'($time);
            check(n < 60, "command not accepted");
            g = (t_done[i] - t_done[rows[i].ref_row]) / CLK_NS;
            check(g >= rows[i].gap, "cross-bank gap too short");
        end
        idle_wait(4'hF, k0);
        // the last read's beats arrive after its bank has gone idle
        repeat (12) @(posedge i_mclk);
        #1;
        check(wr_beats == 6 && rd_beats == 6, "beat count");
        check(ctl_idle === 4'hF, "tracker not idle");
        $display("test table done");
        issue(CMD_RD, 2'h0, 1'b0, 20, n);
        check(n == 20, "read to idle bank accepted");
        issue(CMD_NOP, 2'h0, 1'b0, 20, n);
        check(n == 20, "nop request accepted");
        issue(CMD_REF, 2'h0, 1'b0, 20, n);
        check(n < 20, "refresh refused when idle");
        issue(CMD_LMR, 2'h0, 1'b0, 20, n);
        check(n < 20, "mode load refused when idle");
        issue(CMD_ACT, 2'h1, 1'b0, 60, n);
        issue(CMD_REF, 2'h0, 1'b0, 20, n);
        check(n == 20, "refresh with open bank");
        issue(CMD_PRE, 2'h1, 1'b0, 60, n);
        issue(CMD_DTD, 2'h0, 1'b0, 20, n);
        $display("test refusal done");
        // the plain precharge is the baseline, so pipeline offsets cancel
        issue(CMD_ACT, 2'h2, 1'b0, 60, n);
        issue(CMD_PRE, 2'h2, 1'b0, 60, n);
        idle_wait(4'h4, k0);
        issue(CMD_ACT, 2'h2, 1'b0, 60, n);
        issue(CMD_RD, 2'h2, 1'b1, 60, n);
        idle_wait(4'h4, k1);
        check(k1 - k0 == BL2, "read ap precharge start");
        wr_mask = 4'hF;
        b0 = wr_beats;
        issue(CMD_ACT, 2'h2, 1'b0, 60, n);
        issue(CMD_WR, 2'h2, 1'b1, 60, n);
        idle_wait(4'h4, k2);
        check(k2 - k0 == WR_PIPE + WR_CYC, "write ap precharge start");
        check(wr_beats == b0, "masked beat delivered");
        check(terms > 0, "terminator disable not seen");
        $display("test precharge done");
        test_done();
    end
endmodule
